// >>> rtl/serial_fifo_pkg.sv
package serial_fifo_pkg;
  localparam int DATA_W = 8;
  localparam int LVL_W = 5;
  localparam int BUF_DEPTH = 16;
  localparam int CFG_W = 8;
  localparam int CTRL_W = 6;

  localparam logic [7:0] FIFO_CONFIG_OFS = 8'h00;
  localparam logic [7:0] CHANNEL_CTRL_OFS = 8'h04;
  localparam logic [7:0] CHANNEL_STATUS_OFS = 8'h08;
  localparam logic [7:0] TX_DATA_OFS = 8'h0c;
  localparam logic [7:0] RX_DATA_OFS = 8'h10;

  localparam int CFG_FIFO_EN_BIT = 0;
  localparam int CFG_AUTO_DIS_BIT = 1;
  localparam int CFG_RX_IRQ_EN_BIT = 2;
  localparam int CFG_TX_IRQ_EN_BIT = 3;
  localparam int CFG_RX_DEPTH_SEL_BIT = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_TX_EN_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_FILL_LSB = 4;
  localparam int CTRL_RX_CLR_BIT = 6;
  localparam int CTRL_TX_CLR_BIT = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  localparam int STAT_RX_LVL_LSB = 0;
  localparam int STAT_TX_LVL_LSB = 8;

  localparam logic [1:0] MODE_HALF_RX = 2'h0;
  localparam logic [1:0] MODE_HALF_TX = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;

  localparam logic [LVL_W-1:0] HALF_DEPTH = 5'h04;
  localparam logic [LVL_W-1:0] FULL_DEPTH = 5'h02;
  localparam logic [LVL_W-1:0] BYPASS_DEPTH = 5'h01;
  localparam logic [LVL_W-1:0] NO_DEPTH = 5'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// >>> rtl/serial_fifo_config.sv
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// What this block does
// - receive depth select picks full configured depth or the receive interrupt fill level.
// - with fifo enabled, transmit interrupts follow the transmit interrupt enable.
// - with fifo enabled, receive interrupts follow the receive interrupt enable.
// - auto disable clears receive enable when shifter, buffer and receive fifo are full.
// - auto disable clears transmit enable when fifo, buffer and shifter are all empty.
// - with both directions on, either limit clears both enables.
// - fifo enable bit one turns fifos on; zero bypasses them.
// - depth split: half receive 4, half transmit 4, full duplex 2 each.
// - with fifo enabled, transmit fifo always offers its full configured depth.
// - transmit level counts bytes written and not yet moved out.
// - fill codes 0..3 give 4,1,2,3 half duplex and 2,1,2,1 full duplex.

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [LVL_W-1:0] cap,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [LVL_W-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // cap lets the owner shrink usable depth without touching the storage
  assign in_ready = (cnt_ff < cap) && (cnt_ff < LVL_W'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign count = cnt_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end else begin
      if (push) begin
        nxt_wr = wr_ff + PTR_W'(1);
      end
      if (pop) begin
        nxt_rd = rd_ff + PTR_W'(1);
      end
      nxt_cnt = cnt_ff + LVL_W'(push) - LVL_W'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage is not reset; the count guards every read
  always_ff @(posedge clk) begin
    if (push && !clear) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule // stream_fifo

module serial_fifo_config (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [serial_fifo_pkg::DATA_W-1:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_SHIFT_BUSY,
  input wire logic [serial_fifo_pkg::DATA_W-1:0] RX_DATA,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic RX_SHIFT_FULL,
  output logic RX_ENABLE,
  output logic TX_ENABLE,
  output logic TX_IRQ,
  output logic RX_IRQ
);
  import serial_fifo_pkg::*;

  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
  endfunction

  function automatic logic [LVL_W-1:0] fill_bytes(input logic [1:0] code, input logic full_dup);
    case (code)
      2'h0: fill_bytes = full_dup ? 5'h02 : 5'h04;
      2'h1: fill_bytes = 5'h01;
      2'h2: fill_bytes = 5'h02;
      default: fill_bytes = full_dup ? 5'h01 : 5'h03;
    endcase
  endfunction

  logic [CFG_W-1:0] cfg_ff, nxt_cfg;
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic wr_pend_ff, nxt_wr_pend;
  logic [31:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic tx_irq_ff, nxt_tx_irq, rx_irq_ff, nxt_rx_irq;
  logic acc, rd_acc, wr_cfg, wr_ctrl, wr_tx, rd_rx;
  logic fifo_en, auto_dis, full_dup, rx_en, tx_en;
  logic [1:0] mode;
  logic [LVL_W-1:0] fill, cfg_rx_depth, cfg_tx_depth, rx_cap, tx_cap, rx_cnt, tx_cnt;
  logic rx_limit, tx_limit, clr_rx_en, clr_tx_en;
  logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
  logic [DATA_W-1:0] rx_head;

  assign acc = HSEL && HTRANS[1] && HREADY;
  assign rd_acc = acc && !HWRITE;
  assign wr_cfg = wr_pend_ff && hit(wr_addr_ff, FIFO_CONFIG_OFS);
  assign wr_ctrl = wr_pend_ff && hit(wr_addr_ff, CHANNEL_CTRL_OFS);
  assign wr_tx = wr_pend_ff && hit(wr_addr_ff, TX_DATA_OFS);
  assign rd_rx = rd_acc && hit(HADDR, RX_DATA_OFS) && rx_out_valid;

  assign fifo_en = cfg_ff[CFG_FIFO_EN_BIT];
  assign auto_dis = cfg_ff[CFG_AUTO_DIS_BIT];
  assign rx_en = ctrl_ff[CTRL_RX_EN_BIT];
  assign tx_en = ctrl_ff[CTRL_TX_EN_BIT];
  assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
  assign full_dup = mode[1];
  assign fill = fill_bytes(ctrl_ff[CTRL_FILL_LSB +: 2], full_dup);

  // storage split follows the transfer mode
  always_comb begin
    cfg_rx_depth = NO_DEPTH;
    cfg_tx_depth = NO_DEPTH;
    if (full_dup) begin
      cfg_rx_depth = FULL_DEPTH;
      cfg_tx_depth = FULL_DEPTH;
    end else if (mode == MODE_HALF_RX) begin
      cfg_rx_depth = HALF_DEPTH;
    end else begin
      cfg_tx_depth = HALF_DEPTH;
    end
  end

  // bypass leaves a single holding slot per direction
  assign rx_cap = !fifo_en ? BYPASS_DEPTH :
    ((cfg_ff[CFG_RX_DEPTH_SEL_BIT] && cfg_rx_depth != NO_DEPTH) ? fill : cfg_rx_depth);
  assign tx_cap = fifo_en ? cfg_tx_depth : BYPASS_DEPTH;

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH), .LVL_W(LVL_W)) tx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .clear(wr_ctrl && HWDATA[CTRL_TX_CLR_BIT]),
    .cap(tx_cap),
    .in_valid(wr_tx),
    .in_ready(tx_in_ready),
    .in_data(HWDATA[DATA_W-1:0]),
    .out_valid(tx_out_valid),
    .out_ready(TX_READY && tx_en),
    .out_data(TX_DATA),
    .count(tx_cnt)
  );

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH), .LVL_W(LVL_W)) rx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .clear(wr_ctrl && HWDATA[CTRL_RX_CLR_BIT]),
    .cap(rx_cap),
    .in_valid(RX_VALID && rx_en),
    .in_ready(rx_in_ready),
    .in_data(RX_DATA),
    .out_valid(rx_out_valid),
    .out_ready(rd_rx),
    .out_data(rx_head),
    .count(rx_cnt)
  );

  assign TX_VALID = tx_out_valid && tx_en;
  assign RX_READY = rx_in_ready && rx_en;

  // limits as seen by the shifters behind this block
  assign rx_limit = RX_SHIFT_FULL && !rx_in_ready;
  assign tx_limit = (tx_cnt == NO_DEPTH) && !TX_SHIFT_BUSY;
  assign clr_rx_en = auto_dis && rx_en && (rx_limit || (tx_en && tx_limit));
  assign clr_tx_en = auto_dis && tx_en && (tx_limit || (rx_en && rx_limit));

  // a software write to the control word in the same cycle wins over the automatic clear
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_cfg) begin
      nxt_cfg = HWDATA[CFG_W-1:0];
    end
    if (wr_ctrl) begin
      nxt_ctrl = HWDATA[CTRL_W-1:0];
    end else begin
      nxt_ctrl[CTRL_RX_EN_BIT] = rx_en && !clr_rx_en;
      nxt_ctrl[CTRL_TX_EN_BIT] = tx_en && !clr_tx_en;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cfg_ff <= CFG_RESET;
      ctrl_ff <= CTRL_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // bypass keeps plain single-byte interrupts; fifo mode gates them by the enables
  always_comb begin
    nxt_tx_irq = tx_en && (tx_cnt == NO_DEPTH);
    nxt_rx_irq = (rx_cnt != NO_DEPTH);
    if (fifo_en) begin
      nxt_tx_irq = cfg_ff[CFG_TX_IRQ_EN_BIT] && tx_en && (tx_cnt == NO_DEPTH);
      nxt_rx_irq = cfg_ff[CFG_RX_IRQ_EN_BIT] && (rx_cnt >= fill);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= nxt_tx_irq;
      rx_irq_ff <= nxt_rx_irq;
    end
  end

  // read data is formed in the address phase, so the slave never inserts wait states
  always_comb begin
    nxt_wr_pend = acc && HWRITE;
    nxt_wr_addr = acc ? HADDR : wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    if (rd_acc) begin
      nxt_hrdata = 32'h00000000;
      if (hit(HADDR, FIFO_CONFIG_OFS)) begin
        nxt_hrdata[CFG_W-1:0] = cfg_ff;
      end else if (hit(HADDR, CHANNEL_CTRL_OFS)) begin
        nxt_hrdata[CTRL_W-1:0] = ctrl_ff;
      end else if (hit(HADDR, CHANNEL_STATUS_OFS)) begin
        nxt_hrdata[STAT_RX_LVL_LSB +: LVL_W] = rx_cnt;
        nxt_hrdata[STAT_TX_LVL_LSB +: LVL_W] = tx_cnt;
      end else if (rd_rx) begin
        nxt_hrdata[DATA_W-1:0] = rx_head;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
      hrdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign HRDATA = hrdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;
  assign RX_ENABLE = rx_en;
  assign TX_ENABLE = tx_en;
  assign TX_IRQ = tx_irq_ff;
  assign RX_IRQ = rx_irq_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence cfg_read_s;
    rd_acc && hit(HADDR, FIFO_CONFIG_OFS);
  endsequence

  sequence tx_push_only_s;
    wr_tx && tx_in_ready && !(TX_VALID && TX_READY) && !wr_ctrl;
  endsequence

  cfg_upper_zero_a: assert property (cfg_read_s |=> HRDATA[31:8] == 24'h000000)
    else $error("config read shows nonzero upper bits");
  tx_irq_gate_a: assert property (fifo_en && !cfg_ff[CFG_TX_IRQ_EN_BIT] |=> !TX_IRQ)
    else $error("transmit interrupt raised while disabled");
  rx_irq_gate_a: assert property (fifo_en && !cfg_ff[CFG_RX_IRQ_EN_BIT] |=> !RX_IRQ)
    else $error("receive interrupt raised while disabled");
  rx_auto_clear_a: assert property (auto_dis && rx_en && rx_limit && !wr_ctrl |=> !RX_ENABLE)
    else $error("receive enable not cleared at receive limit");
  tx_auto_clear_a: assert property (auto_dis && tx_en && tx_limit && !wr_ctrl |=> !TX_ENABLE)
    else $error("transmit enable not cleared when drained");
  both_auto_clear_a: assert property (auto_dis && rx_en && tx_en && (rx_limit || tx_limit) && !wr_ctrl
    |=> !RX_ENABLE && !TX_ENABLE)
    else $error("both enables not cleared on a limit");
  bypass_depth_a: assert property (!fifo_en && tx_cnt != NO_DEPTH |-> !tx_in_ready)
    else $error("bypass accepts a second transmit byte");
  full_split_a: assert property (fifo_en && full_dup && tx_cnt >= FULL_DEPTH |-> !tx_in_ready)
    else $error("full duplex transmit depth exceeded");
  rx_depth_sel_a: assert property (fifo_en && cfg_ff[CFG_RX_DEPTH_SEL_BIT] && mode == MODE_HALF_RX
    && rx_cnt >= fill |-> !RX_READY)
    else $error("receive depth beyond selected fill level");
  tx_level_a: assert property (tx_push_only_s |=> tx_cnt == $past(tx_cnt) + 5'h01)
    else $error("transmit level misses a written byte");
endmodule // serial_fifo_config

// >>> testbench/serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_busy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_full,
  input wire logic tx_stall,
  input wire logic rx_send,
  input wire logic rx_full_req,
  output logic [7:0] got_count,
  output logic [7:0] got_last
);
  logic [1:0] busy_ff;
  logic [7:0] byte_ff;
  // shifter holds each byte three cycles, so the empty limit lags the fifo
  assign tx_ready = !tx_stall && busy_ff == 2'h0;
  assign tx_busy = busy_ff != 2'h0;
  assign rx_valid = rx_send;
  // idle data line shows the inverse, so a stale byte never passes as fresh
  assign rx_data = rx_send ? byte_ff : ~byte_ff;
  assign rx_full = rx_full_req;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 2'h0;
      byte_ff <= 8'h30;
      got_count <= 8'h00;
      got_last <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        busy_ff <= 2'h3;
        got_count <= got_count + 8'h01;
        got_last <= tx_data;
      end else if (busy_ff != 2'h0) begin
        busy_ff <= busy_ff - 2'h1;
      end
      if (rx_valid && rx_ready) begin
        byte_ff <= byte_ff + 8'h01;
      end
    end
  end
endmodule // serial_peer

// >>> testbench/serial_fifo_config_test.sv
`timescale 1ns/10ps
module serial_fifo_config_test;
  import serial_fifo_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, TX_VALID, TX_READY, TX_SHIFT_BUSY, RX_VALID, RX_READY, RX_SHIFT_FULL;
  logic RX_ENABLE, TX_ENABLE, TX_IRQ, RX_IRQ;
  logic [DATA_W-1:0] TX_DATA, RX_DATA;
  logic tx_stall = 1'b0;
  logic rx_send = 1'b0;
  logic rx_full_req = 1'b0;
  logic [7:0] got_count, got_last;
  int num_errors = 0;
  int compares = 0;
  int seed = 32'h46333bc9;
  always #20 CLK_SYS = ~CLK_SYS;
  serial_fifo_config dut (.HREADY(HREADYOUT), .*);
  serial_peer peer (.clk(CLK_SYS), .rst(RST), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY),
    .tx_busy(TX_SHIFT_BUSY), .rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_ready(RX_READY),
    .rx_full(RX_SHIFT_FULL), .tx_stall(tx_stall), .rx_send(rx_send), .rx_full_req(rx_full_req),
    .got_count(got_count), .got_last(got_last));
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        report_and_stop;
      end
      @(posedge CLK_SYS);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    wait_ready;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready;
    q = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  function automatic logic [4:0] fill_of(input logic [1:0] md, input logic [1:0] c);
    if (md == MODE_HALF_RX || md == MODE_HALF_TX) return (c == 2'h0) ? 5'h04 : 5'(c);
    return c[0] ? 5'h01 : 5'h02;
  endfunction
  function automatic logic [4:0] rx_depth(input logic en, input logic [1:0] md, input logic ds, input logic [1:0] c);
    if (!en) return BYPASS_DEPTH;
    if (md == MODE_HALF_TX) return NO_DEPTH;
    if (ds) return fill_of(md, c);
    return (md == MODE_HALF_RX) ? HALF_DEPTH : FULL_DEPTH;
  endfunction
  function automatic logic [4:0] tx_depth(input logic en, input logic [1:0] md);
    if (!en) return BYPASS_DEPTH;
    if (md == MODE_HALF_RX) return NO_DEPTH;
    return (md == MODE_HALF_TX) ? HALF_DEPTH : FULL_DEPTH;
  endfunction
  initial begin
    idle(60000);
    num_errors++;
    report_and_stop;
  end
  initial begin
    logic [31:0] v;
    logic [4:0] lvl;
    logic [7:0] last, base, rx_next;
    logic [1:0] md;
    logic ds, rie, tie;
    // the peer counts its receive bytes up from this value after reset
    rx_next = 8'h30;
    idle(2);
    RST <= 1'b0;
    idle(1);
    bus(1'b0, FIFO_CONFIG_OFS, 32'h0, v);
    check(v, 32'(CFG_RESET));
    check(32'({TX_ENABLE, RX_ENABLE, TX_IRQ, RX_IRQ, TX_VALID, RX_READY, HRESP}), 32'h0);
    wr(FIFO_CONFIG_OFS, 32'hffffff1f);
    bus(1'b0, FIFO_CONFIG_OFS, 32'h0, v);
    check(v, 32'h0000001f);
    bus(1'b0, 8'h40, 32'h0, v);
    check(v, 32'h0);
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 4; m++) begin
        for (int c = 0; c < 4; c++) begin
          rie = 1'($random(seed));
          tie = 1'($random(seed));
          ds = 1'($random(seed)) & e[0] & (m != 1);
          // mode, then fifo config, then clears; no nine-bit frames exist here
          wr(CHANNEL_CTRL_OFS, 32'(m << 2));
          wr(FIFO_CONFIG_OFS, 32'({ds, tie, rie, 1'b0, e[0]}));
          wr(CHANNEL_CTRL_OFS, 32'(8'hc1 | c << 4 | m << 2));
          rx_send <= 1'b1;
          repeat (6) wr(TX_DATA_OFS, 32'($random(seed)) & 32'hff);
          rx_send <= 1'b0;
          bus(1'b0, CHANNEL_STATUS_OFS, 32'h0, v);
          lvl = rx_depth(e[0], m[1:0], ds, c[1:0]);
          check(32'(v[12:8]), 32'(tx_depth(e[0], m[1:0])));
          check(32'(v[4:0]), 32'(lvl));
          check(32'(RX_IRQ), 32'(e ? (rie && lvl >= fill_of(m[1:0], c[1:0])) : (lvl != 0)));
          check(32'({RX_READY, TX_VALID}), 32'h0);
          // head byte pops through the data register; an empty fifo reads zero
          bus(1'b0, RX_DATA_OFS, 32'h0, v);
          check(v, (lvl != 0) ? 32'(rx_next) : 32'h0);
          rx_next = rx_next + 8'(lvl);
        end
      end
    end
    for (int t = 0; t < 2; t++) begin
      wr(CHANNEL_CTRL_OFS, 32'h4);
      wr(FIFO_CONFIG_OFS, 32'(t << 3 | 1));
      wr(CHANNEL_CTRL_OFS, 32'hc4);
      base = got_count;
      for (int i = 0; i < 3; i++) begin
        last = 8'($random(seed));
        wr(TX_DATA_OFS, 32'(last));
      end
      wr(CHANNEL_CTRL_OFS, 32'h6);
      for (int i = 0; i < 200 && got_count !== base + 8'h3; i++) begin
        tx_stall <= 1'($random(seed));
        idle(1);
      end
      if (got_count !== base + 8'h3) begin
        num_errors++;
        report_and_stop;
      end
      tx_stall <= 1'b0;
      idle(6);
      check(32'(got_last), 32'(last));
      check(32'({TX_ENABLE, TX_IRQ}), 32'({1'b1, t[0]}));
      wr(FIFO_CONFIG_OFS, 32'(t << 3 | 3));
      idle(4);
      check(32'({TX_ENABLE, TX_IRQ}), 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      md = k ? MODE_FULL : MODE_HALF_RX;
      wr(CHANNEL_CTRL_OFS, 32'({md, 2'h0}));
      wr(FIFO_CONFIG_OFS, 32'h3);
      wr(CHANNEL_CTRL_OFS, 32'({4'hc, md, 2'h0}));
      wr(TX_DATA_OFS, 32'h5a);
      tx_stall <= 1'b1;
      rx_send <= 1'b1;
      wr(CHANNEL_CTRL_OFS, 32'({4'h0, md, k[0], 1'b1}));
      idle(8);
      check(32'({TX_ENABLE, RX_ENABLE}), 32'({k[0], 1'b1}));
      rx_full_req <= 1'b1;
      idle(3);
      check(32'({TX_ENABLE, RX_ENABLE}), 32'h0);
      rx_full_req <= 1'b0;
      rx_send <= 1'b0;
      tx_stall <= 1'b0;
    end
    // a second reset mid-run must bring every register and level back
    RST <= 1'b1;
    idle(2);
    RST <= 1'b0;
    idle(1);
    check(32'({TX_ENABLE, RX_ENABLE, TX_IRQ, RX_IRQ, TX_VALID, RX_READY}), 32'h0);
    bus(1'b0, FIFO_CONFIG_OFS, 32'h0, v);
    check(v, 32'(CFG_RESET));
    bus(1'b0, CHANNEL_STATUS_OFS, 32'h0, v);
    check(v, 32'h0);
    report_and_stop;
  end
endmodule // serial_fifo_config_test
